/* File: rtl/dwsc_defines.svh */
// Timing counts and protocol constants for the dual wiper serial control link.
// Assumes a 200 MHz system clock shared by both ends.
`ifndef DWSC_DEFINES_SVH
`define DWSC_DEFINES_SVH

// =====================================================
// Frame layout
`define DWSC_START_BIT      1'b1
`define DWSC_ADDR_OUT1      2'b10
`define DWSC_ADDR_OUT2      2'b11
`define DWSC_FRAME_BITS     11
`define DWSC_GAP_CYCLES     2

// =====================================================
// Timing
`define DWSC_CLK_PERIOD_NS  5
`define DWSC_STORE_SETUP_NS 150
`define DWSC_STORE_SETUP_CYC ((`DWSC_STORE_SETUP_NS + `DWSC_CLK_PERIOD_NS - 1) / `DWSC_CLK_PERIOD_NS)
`define DWSC_NV_CYCLE_MS    5
`define DWSC_NV_CYCLE_CYC   (`DWSC_NV_CYCLE_MS * 1000000 / `DWSC_CLK_PERIOD_NS)

// =====================================================
// Reset values
`define DWSC_WIPER_RESET    8'h80

`endif

/* File: rtl/dwsc_device.sv */
// Device end: serial wiper control with volatile wipers and non-volatile copies.
// Assumes link pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "dwsc_defines.svh"

// What this block does
// [RULE1] Store request drives status low until done
// [RULE2] Ignore input, drive nothing while programming
// [RULE3] Status stays high when supply too low
// [RULE4] Shift out after start and address
// [RULE5] Output driver enabled only while selected
// [RULE6] Start, two address, eight data bits
// [RULE7] Output updates cycle after final data bit
// [RULE8] Host raises store request early enough
// [RULE9] Ready for new frame two cycles later
// [RULE10] Host keeps clock running while programming
// [RULE11] Every transfer shifts old contents out
// [RULE12] Early deselect reloads stored value
// [RULE13] Temporary settings revert when select falls
// [RULE14] Unstored data dropped after two cycles
// [RULE15] Start bit one, fields LSB first
// [RULE16] Address 10 first output, 11 second
// [RULE17] Host leaves two cycles between frames
// [RULE18] Power-up loads wipers from storage; reset here loads both wipers and both copies with DWSC_WIPER_RESET
// [RULE19] Per output wiper and non-volatile copy
// [RULE20] Cut frames change nothing, start nothing
module dwsc_device
  import dwsc_pkg::*;
#(
  parameter int NV_CYCLES = `DWSC_NV_CYCLE_CYC
)
(
  // System
  input  wire logic        clk,
  input  wire logic        resetn,
  // Link
  dwsc_link_if.device      link,
  // Supply monitor
  input  wire logic        supply_low,
  // Programmable outputs
  output logic [7:0]       programmable_output1,
  output logic [7:0]       programmable_output2
);

  // =====================================================
  // Pin synchronisers
  logic [1:0] sel_s, clk_s, din_s, req_s, low_s;
  logic       sclk_d, req_d, sel_d;

  always_ff @(posedge clk)
  begin
    sel_s <= {sel_s[0], link.select};
    clk_s <= {clk_s[0], link.sclk};
    din_s <= {din_s[0], link.serial_in};
    req_s <= {req_s[0], link.store_request};
    low_s <= {low_s[0], supply_low};
    sclk_d <= clk_s[1];
    req_d <= req_s[1];
    sel_d <= sel_s[1];
  end

  wire rise     = clk_s[1] & ~sclk_d;
  wire req_rise = req_s[1] & ~req_d;
  wire sel_fall = ~sel_s[1] & sel_d;

  // =====================================================
  // Frame sequencer
  dwsc_state_e state;
  logic [3:0]  cnt;
  logic [1:0]  addr;
  logic [7:0]  shreg;
  logic        armed;
  logic [$clog2(NV_CYCLES+1)-1:0] nv_cnt;
  dwsc_wiper_t wiper [2];
  dwsc_wiper_t nvcopy [2];

  function automatic logic sel_idx(input logic [1:0] a);
    return a[0];                                              // [RULE16]
  endfunction

  function automatic logic addr_ok(input logic [1:0] a);
    return a[1];                                              // [RULE16]
  endfunction

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= DWSC_IDLE;
      cnt   <= 4'h0;
      addr  <= 2'h0;
      armed <= 1'b0;
    end
    else if (!sel_s[1] && state != DWSC_BUSY)
    begin
      state <= DWSC_IDLE;                                     // [RULE20]
      armed <= 1'b0;
    end
    else
    begin
      if (req_rise && state inside {DWSC_ADDR, DWSC_DATA})
        armed <= 1'b1;                                        // [RULE8]
      case (state)
        DWSC_IDLE:
          if (rise && din_s[1] == `DWSC_START_BIT)
          begin
            state <= DWSC_ADDR;                               // [RULE15]
            cnt   <= 4'h0;
            armed <= 1'b0;
          end
        DWSC_ADDR:
          if (rise)
          begin
            addr <= {din_s[1], addr[1]};                      // [RULE15]
            cnt  <= cnt + 4'h1;
            if (cnt == 4'h1)
            begin
              state <= DWSC_DATA;                             // [RULE4]
              cnt   <= 4'h0;
            end
          end
        DWSC_DATA:
          if (rise)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h7)
            begin
              state <= DWSC_GAP;                              // [RULE6]
              cnt   <= 4'h0;
            end
          end
        DWSC_GAP:
          if (rise)
          begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h0 && (armed || req_s[1]) && addr_ok(addr) && !low_s[1])
              state <= DWSC_BUSY;                             // [RULE1]
            else if (cnt == 4'(`DWSC_GAP_CYCLES - 1))
            begin
              state <= DWSC_IDLE;                             // [RULE9] [RULE14]
              armed <= 1'b0;
            end
          end
        DWSC_BUSY:
          if (nv_cnt == '0)
          begin
            state <= DWSC_IDLE;
            armed <= 1'b0;
          end
        default:
          state <= DWSC_IDLE;
      endcase
    end
  end

  // Programming time is counted in system clocks; the host still keeps the serial clock running
  always_ff @(posedge clk)
  begin
    if (!resetn)
      nv_cnt <= '0;
    else if (state == DWSC_GAP && cnt == 4'h0 && rise)
      nv_cnt <= ($clog2(NV_CYCLES+1))'(NV_CYCLES);
    else if (state == DWSC_BUSY && nv_cnt != '0)
      nv_cnt <= nv_cnt - 1'b1;                                // [RULE10]
  end

  // =====================================================
  // Shift register and wipers
  always_ff @(posedge clk)
  begin
    if (!resetn)
      shreg <= 8'h00;
    else if (state == DWSC_ADDR && rise && cnt == 4'h1)
      shreg <= wiper[sel_idx({din_s[1], addr[1]})];           // [RULE11]
    else if (state == DWSC_DATA && rise)
      shreg <= {din_s[1], shreg[7:1]};                        // [RULE11] [RULE15]
  end

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_wiper
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          nvcopy[i] <= `DWSC_WIPER_RESET;                     // [RULE19]
          wiper[i]  <= `DWSC_WIPER_RESET;                     // [RULE18]
        end
        else
        begin
          if (sel_fall)
            wiper[i] <= nvcopy[i];                            // [RULE12] [RULE13]
          else if (state == DWSC_GAP && cnt == 4'h0 && rise
                   && addr_ok(addr) && sel_idx(addr) == i)
            wiper[i] <= shreg;                                // [RULE7]
          if (state == DWSC_BUSY && nv_cnt == '0 && sel_idx(addr) == i)
            nvcopy[i] <= wiper[i];                            // [RULE19]
        end
      end
    end
  endgenerate

  // =====================================================
  // Pin outputs
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      link.dev_serial_out  <= 1'b0;
      link.dev_serial_oe   <= 1'b0;
      link.nv_write_status <= 1'b1;
      programmable_output1 <= `DWSC_WIPER_RESET;
      programmable_output2 <= `DWSC_WIPER_RESET;
    end
    else
    begin
      link.dev_serial_oe   <= sel_s[1] && state != DWSC_BUSY;  // [RULE5] [RULE2]
      link.dev_serial_out  <= (state == DWSC_DATA) ? shreg[0] : 1'b0; // [RULE4]
      // Status gated by the supply monitor so a failed store never shows busy
      link.nv_write_status <= !((state == DWSC_BUSY) && !low_s[1]); // [RULE1] [RULE3]
      programmable_output1 <= wiper[0];
      programmable_output2 <= wiper[1];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/dwsc_host.sv */
// Host end: sends one frame on request, returns the bits read back.
// Assumes the device end is on the same system clock.
`timescale 1ns/1ps
`default_nettype none
`include "dwsc_defines.svh"

module dwsc_host
  import dwsc_pkg::*;
#(
  parameter int HALF_PERIOD = 100
)
(
  // System
  input  wire logic        clk,
  input  wire logic        resetn,
  // User requests
  input  wire logic        cmd_valid,
  input  wire logic        cmd_second_output,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_store,
  input  wire logic        cmd_read_only,
  output logic             cmd_ready,
  output logic [7:0]       read_data,
  output logic             read_valid,
  // Link
  dwsc_link_if.host        link
);

  // =====================================================
  // Clock divider and bit sequencer
  logic [7:0]  div;
  logic        tick;
  logic [3:0]  bitn;
  logic [10:0] frame;
  logic        store, ronly, busy;
  logic [1:0]  st_s;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      div  <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (div == 8'(HALF_PERIOD - 1));
      div  <= (div == 8'(HALF_PERIOD - 1)) ? 8'h00 : div + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    st_s <= {st_s[0], link.nv_write_status};
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      cmd_ready <= 1'b0;
      link.select <= 1'b0;
      link.sclk <= 1'b0;
      link.serial_in <= 1'b0;
      link.store_request <= 1'b0;
      bitn <= 4'h0;
      frame <= 11'h000;
      store <= 1'b0;
      ronly <= 1'b0;
      read_data <= 8'h00;
      read_valid <= 1'b0;
    end
    else
    begin
      read_valid <= 1'b0;
      // Ready must not wait for valid to drop, or a held request would never be taken
      cmd_ready <= !busy;
      if (!busy && cmd_valid && cmd_ready)
      begin
        busy <= 1'b1;
        cmd_ready <= 1'b0;
        // Start bit stands before the first rising clock, so no empty clock leads the block
        link.serial_in <= `DWSC_START_BIT;                    // [RULE15] [RULE6]
        frame <= {1'b0, cmd_data,
                  cmd_second_output ? `DWSC_ADDR_OUT2 : `DWSC_ADDR_OUT1}; // [RULE15] [RULE16]
        store <= cmd_store;
        ronly <= cmd_read_only;
        bitn <= 4'h1;
        link.select <= 1'b1;
      end
      else if (busy && tick)
      begin
        link.sclk <= ~link.sclk;
        if (link.sclk)
        begin
          // Falling edge: present the next bit
          link.serial_in <= frame[0];
          frame <= {1'b0, frame[10:1]};
          bitn <= bitn + 4'h1;
          if (bitn == 4'h2 && store)
            link.store_request <= 1'b1;                       // [RULE8]
          if (ronly && bitn == 4'(`DWSC_FRAME_BITS + 1))
          begin
            link.select <= 1'b0;                              // [RULE12]
            busy <= 1'b0;
            read_valid <= 1'b1;
          end
          else if (bitn == 4'(`DWSC_FRAME_BITS + `DWSC_GAP_CYCLES + 1)
                   && (!store || st_s[1]))
          begin
            busy <= 1'b0;                                     // [RULE17] [RULE10]
            link.store_request <= 1'b0;
            link.select <= 1'b0;
            read_valid <= 1'b1;
          end
          else if (bitn > 4'(`DWSC_FRAME_BITS + `DWSC_GAP_CYCLES))
            bitn <= bitn;
        end
        else if (bitn >= 4'h4 && bitn <= 4'hb)
          read_data <= {link.serial_out, read_data[7:1]};     // [RULE11]
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/dwsc_link_if.sv */
// Wires between the host and the dual wiper device.
// Assumes both ends share the system clock; serial_out is resolved from its enable.
`timescale 1ns/1ps
`default_nettype none
interface dwsc_link_if;
  logic select;
  logic sclk;
  logic serial_in;
  logic store_request;
  logic dev_serial_out;
  logic dev_serial_oe;
  logic nv_write_status;
  wire  serial_out = dev_serial_oe ? dev_serial_out : 1'b1;

  modport device
  (
    input  select, sclk, serial_in, store_request,
    output dev_serial_out, dev_serial_oe, nv_write_status
  );
  modport host
  (
    output select, sclk, serial_in, store_request,
    input  serial_out, nv_write_status, dev_serial_oe
  );
endinterface
`default_nettype wire

/* File: rtl/dwsc_pkg.sv */
// Types shared by both ends of the dual wiper serial control link.
// Assumes dwsc_defines.svh supplies the numbers.
package dwsc_pkg;
  typedef enum logic [2:0]
  {
    DWSC_IDLE  = 3'b000,
    DWSC_ADDR  = 3'b001,
    DWSC_DATA  = 3'b011,
    DWSC_GAP   = 3'b010,
    DWSC_BUSY  = 3'b110
  } dwsc_state_e;
  typedef logic [7:0] dwsc_wiper_t;
endpackage

/* File: verification/dwsc_link_props.sv */
// Checker for the wires between host and device.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dwsc_link_props
#(
  parameter int NV_CYCLES   = 50,
  parameter int HALF_PERIOD = 6
)
(
  // System
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire logic select,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic store_request,
  input wire logic dev_serial_out,
  input wire logic dev_serial_oe,
  input wire logic nv_write_status
);
  localparam int LO = NV_CYCLES - 4;
  localparam int HP = HALF_PERIOD + 1;
  logic [7:0] nbit;
  logic       sclk_q;
  wire        sclk_rise = sclk && !sclk_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================
  // Frame bit counter
  always_ff @(posedge clk)
  begin
    sclk_q <= sclk;
  end
  // Saturates so the clocks run during programming cannot wrap it
  always_ff @(posedge clk)
  begin
    if (!resetn || !select)
      nbit <= 8'h00;
    else if (sclk_rise && nbit != 8'hff)
      nbit <= nbit + 8'h01;
  end

  // ==========================================
  // Assertions
  AST_OE_OFF: assert property (!select [*4] |-> !dev_serial_oe)
    else $error("serial output driven while deselected");
  AST_OE_ON: assert property ((select && nv_write_status) [*6] |-> dev_serial_oe)
    else $error("serial output idle while selected");
  AST_BUSY_QUIET: assert property (!nv_write_status [*2] |-> !dev_serial_oe)
    else $error("serial output driven while programming");
  AST_STORE_CAUSE: assert property ($fell(nv_write_status) |-> store_request)
    else $error("status fell without store request");
  AST_BUSY_LEN: assert property
    ($fell(nv_write_status) |-> ##LO !nv_write_status ##[1:10] nv_write_status)
    else $error("programming time out of range");
  AST_SCLK_RUNS: assert property
    (!nv_write_status |-> ##[0:HP] ($changed(sclk) || nv_write_status))
    else $error("serial clock stopped while programming");
  AST_STORE_IN_FRAME: assert property ($rose(store_request) |-> select)
    else $error("store request outside a frame");
  AST_START_ONE: assert property (sclk_rise && select && nbit == 8'h00 |-> serial_in)
    else $error("first bit of frame is not one");
  AST_ADDR_SECOND: assert property (sclk_rise && select && nbit == 8'h02 |-> serial_in)
    else $error("second address bit is not one");

  cover property ($fell(nv_write_status));
  cover property ($rose(dev_serial_oe));
  cover property ($fell(select) && nbit < 8'h0d);
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Bench joining host and device through the link interface.
// Assumes a 200 MHz clock and a shortened programming time.
`timescale 1ns/1ps
`default_nettype none
`include "dwsc_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench
  import dwsc_pkg::*;
;
  localparam int NV = 50;
  localparam int HP = 6;
  logic        clk;
  logic        resetn;
  logic        cmd_valid;
  logic        cmd_second_output;
  logic [7:0]  cmd_data;
  logic        cmd_store;
  logic        cmd_read_only;
  logic        cmd_ready;
  logic [7:0]  read_data;
  logic        read_valid;
  logic        supply_low;
  dwsc_wiper_t out1;
  dwsc_wiper_t out2;
  dwsc_wiper_t nv [2];
  logic [31:0] r;
  int          num_errors;
  int          samples_checked;
  int          cycles;
  int          seed;

  dwsc_link_if link_if ();
  dwsc_host #(.HALF_PERIOD(HP)) dwsc_host_inst
  (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_second_output(cmd_second_output), .cmd_data(cmd_data),
    .cmd_store(cmd_store), .cmd_read_only(cmd_read_only), .cmd_ready(cmd_ready),
    .read_data(read_data), .read_valid(read_valid), .link(link_if.host)
  );
  dwsc_device #(.NV_CYCLES(NV)) dwsc_device_inst
  (
    .clk(clk), .resetn(resetn), .link(link_if.device), .supply_low(supply_low),
    .programmable_output1(out1), .programmable_output2(out2)
  );
  dwsc_link_props #(.NV_CYCLES(NV), .HALF_PERIOD(HP)) dwsc_link_props_inst
  (
    .clk(clk), .resetn(resetn), .select(link_if.select), .sclk(link_if.sclk),
    .serial_in(link_if.serial_in), .store_request(link_if.store_request),
    .dev_serial_out(link_if.dev_serial_out), .dev_serial_oe(link_if.dev_serial_oe),
    .nv_write_status(link_if.nv_write_status)
  );

  // ==========================================
  // Clock, timeout, expectations
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      results();
    end
  end
  function automatic dwsc_wiper_t out_of(input logic sec);
    return sec ? out2 : out1;
  endfunction
  function automatic logic busy_exp(input logic st, input logic ro, input logic sl);
    return st && !ro && !sl;
  endfunction

  // ==========================================
  // One frame: old value reads back, model tracks the stored copies
  task automatic frame(input logic sec, input logic [7:0] d, input logic st,
                       input logic ro, input logic sl);
    int   n;
    logic temp;
    logic busy;
    logic moved;
    temp = 1'h0;
    busy = 1'h0;
    moved = 1'h0;
    n = 0;
    {cmd_second_output, cmd_data, cmd_store, cmd_read_only} = {sec, d, st, ro};
    supply_low = sl;
    cmd_valid = 1'h1;
    do @(negedge clk); while (cmd_ready !== 1'h1 && ++n < 500);
    @(posedge clk);
    #1 cmd_valid = 1'h0;
    n = 0;
    do
    begin
      @(negedge clk);
      if (link_if.select && out_of(sec) === d) temp = 1'h1;
      if (link_if.nv_write_status === 1'h0) busy = 1'h1;
      if (out_of(sec) !== nv[sec]) moved = 1'h1;
    end
    while (read_valid !== 1'h1 && ++n < 2000);
    `CHK("read_data", nv[sec], read_data)
    `CHK("busy_seen", busy_exp(st, ro, sl), busy)
    if (ro) `CHK("read_only_steady", 1'h0, moved)
    else `CHK("temp_seen", 1'h1, temp)
    if (busy_exp(st, ro, sl)) nv[sec] = d;
    repeat (12) @(negedge clk);
    `CHK("out1", nv[0], out1)
    `CHK("out2", nv[1], out2)
    @(posedge clk);
    #1;
  endtask

  task automatic results;
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    seed = 46624;
    clk = 1'h0;
    resetn = 1'h0;
    {cmd_valid, cmd_second_output, cmd_store, cmd_read_only, supply_low} = 5'h00;
    cmd_data = 8'h00;
    {cycles, num_errors, samples_checked} = 0;
    nv[0] = `DWSC_WIPER_RESET;
    nv[1] = `DWSC_WIPER_RESET;
    repeat (4) @(posedge clk);
    #1 resetn = 1'h1;
    repeat (3) @(negedge clk);
    `CHK("out1_reset", nv[0], out1)
    `CHK("out2_reset", nv[1], out2)
    @(posedge clk);
    #1;
    frame(1'h0, 8'h00, 1'h1, 1'h0, 1'h0);
    frame(1'h1, 8'hff, 1'h1, 1'h0, 1'h0);
    frame(1'h0, 8'h5a, 1'h0, 1'h0, 1'h0);
    frame(1'h1, 8'h3c, 1'h1, 1'h0, 1'h1);
    frame(1'h0, nv[0], 1'h0, 1'h1, 1'h0);
    repeat (12)
    begin
      r = $random(seed);
      frame(r[0], r[1] & r[2] ? nv[r[0]] : r[15:8], r[3] & ~(r[1] & r[2]),
            r[1] & r[2], r[4] & r[5]);
    end
    results();
  end
endmodule
`default_nettype wire
